// ===== hdl/lamind_top.sv
// Mode controller and status lamp sequencer for the leak detection board
// What this block does
// - No fault or leak: lamp two seconds on, two seconds off, repeating.
// - Sensor reports leak: leak-alarm mode with fast lamp blink.
// - After leak clears, stay in delay mode five minutes, then normal.
// - Delay mode holds the lamp steadily lit.
// - Any alarm or fault ending passes through the five-minute delay.
// - Two button presses within five seconds start the verification test.
// - Verification test acts as simulated leak with fast blink, five minutes max.
// - Test timeout returns to normal with no technician action.
// - One button press during the test ends it early.
// - Board fault: two blinks, five seconds dark, repeating.
// - No sensor communication: three blinks, five seconds dark, repeating.
// - Sensor internal error: four blinks, five seconds dark, repeating.
// - Relay failure or sensor-line short raises the board fault.
// - Leak or delay disables heating/cooling and runs the indoor blower.
// - Leak during delay re-enters alarm and restarts clear-and-delay later.
`timescale 1ns/1ns
`default_nettype none
module lamind_top #(
   parameter int unsigned MS_CYCLES = lamind_pkg::MS_CYCLES,
   parameter int unsigned DELAY_MS = lamind_pkg::DELAY_MS,
   parameter int unsigned TEST_MS = lamind_pkg::TEST_MS
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic leak_seen,
   input wire logic sensor_link_ok,
   input wire logic sensor_error,
   input wire logic relay_fail,
   input wire logic line_short,
   input wire logic button,
   output logic lamp,
   output logic hvac_enable,
   output logic blower_on,
   output logic [2:0] mode
);
   // Zero would wrap the minus-one compares and stall the time base or a count
   if (MS_CYCLES < 1 || DELAY_MS < 1 || TEST_MS < 1) begin : g_bad_param
      $error("Tick and timing counts must be at least one");
   end

   logic [31:0] pre_r;
   logic tick;
   logic btn_d_r;
   logic press;
   logic [31:0] win_r;
   logic armed_r;
   logic test_r;
   logic [31:0] test_cnt_r;
   logic delay_r;
   logic [31:0] delay_cnt_r;
   logic board_f;
   logic leak_now;
   logic any_fault;
   lamind_pkg::lamind_mode_e mode_r;
   lamind_pkg::lamind_mode_e mode_nxt;
   logic [31:0] pat_r;
   logic [3:0] blinks;
   logic pat_len_hit;
   logic lamp_nxt;

   // Millisecond time base
   always_ff @(posedge sys_clk) begin
      if (srst || pre_r == MS_CYCLES - 1) begin
         pre_r <= 32'h0;
      end else begin
         pre_r <= pre_r + 32'h1;
      end
   end
   assign tick = (pre_r == MS_CYCLES - 1);

   // Button is a clean level; a press is its rising edge
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         btn_d_r <= 1'b0;
      end else begin
         btn_d_r <= button;
      end
   end
   assign press = button && !btn_d_r;

   assign board_f = relay_fail || line_short;
   assign leak_now = sensor_link_ok && leak_seen;
   assign any_fault = board_f || !sensor_link_ok || sensor_error;

   // Double press window; test start and stop
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         armed_r <= 1'b0;
         win_r <= 32'h0;
         test_r <= 1'b0;
         test_cnt_r <= 32'h0;
      end else if (test_r) begin
         armed_r <= 1'b0;
         if (press) begin
            test_r <= 1'b0;
         end else if (tick) begin
            if (test_cnt_r == TEST_MS - 1) begin
               test_r <= 1'b0;
            end else begin
               test_cnt_r <= test_cnt_r + 32'h1;
            end
         end
      end else if (press && armed_r) begin
         armed_r <= 1'b0;
         test_r <= 1'b1;
         test_cnt_r <= 32'h0;
      end else if (press) begin
         armed_r <= 1'b1;
         win_r <= 32'h0;
      end else if (armed_r && tick) begin
         if (win_r == lamind_pkg::PRESS_MS - 1) begin
            armed_r <= 1'b0;
         end else begin
            win_r <= win_r + 32'h1;
         end
      end
   end

   // Delay restarts while any alarm or fault stands; runs out once all clear
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         delay_r <= 1'b0;
         delay_cnt_r <= 32'h0;
      end else if (leak_now || any_fault) begin
         delay_r <= 1'b1;
         delay_cnt_r <= 32'h0;
      end else if (delay_r && tick) begin
         if (delay_cnt_r == DELAY_MS - 1) begin
            delay_r <= 1'b0;
         end else begin
            delay_cnt_r <= delay_cnt_r + 32'h1;
         end
      end
   end

   // Display priority
   always_comb begin
      if (leak_now) begin
         mode_nxt = lamind_pkg::LAMIND_LEAK;
      end else if (board_f) begin
         mode_nxt = lamind_pkg::LAMIND_BOARD;
      end else if (!sensor_link_ok) begin
         mode_nxt = lamind_pkg::LAMIND_COMM;
      end else if (sensor_error) begin
         mode_nxt = lamind_pkg::LAMIND_SENSOR;
      end else if (test_r) begin
         mode_nxt = lamind_pkg::LAMIND_TEST;
      end else if (delay_r) begin
         mode_nxt = lamind_pkg::LAMIND_DELAY;
      end else begin
         mode_nxt = lamind_pkg::LAMIND_NORMAL;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         mode_r <= lamind_pkg::LAMIND_NORMAL;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   // Blink counts per fault mode
   always_comb begin
      case (mode_r)
         lamind_pkg::LAMIND_BOARD: blinks = 4'(lamind_pkg::BOARD_BLINKS);
         lamind_pkg::LAMIND_COMM: blinks = 4'(lamind_pkg::COMM_BLINKS);
         lamind_pkg::LAMIND_SENSOR: blinks = 4'(lamind_pkg::SENSOR_BLINKS);
         default: blinks = 4'h0;
      endcase
   end

   function automatic logic [31:0] pattern_len(input lamind_pkg::lamind_mode_e m,
                                                  input logic [3:0] n);
      case (m)
         lamind_pkg::LAMIND_NORMAL: pattern_len = 2 * lamind_pkg::SLOW_HALF_MS;
         lamind_pkg::LAMIND_LEAK,
         lamind_pkg::LAMIND_TEST: pattern_len = 2 * lamind_pkg::FAST_HALF_MS;
         lamind_pkg::LAMIND_DELAY: pattern_len = 32'h1;
         default: pattern_len = 32'(n) * 2 * lamind_pkg::FLASH_HALF_MS
                                + lamind_pkg::FAULT_GAP_MS;
      endcase
   endfunction

   assign pat_len_hit = (pat_r >= pattern_len(mode_r, blinks) - 1);

   // Pattern phase restarts on every mode change so each pattern begins cleanly
   always_ff @(posedge sys_clk) begin
      if (srst || mode_r != mode_nxt) begin
         pat_r <= 32'h0;
      end else if (tick) begin
         pat_r <= pat_len_hit ? 32'h0 : pat_r + 32'h1;
      end
   end

   always_comb begin
      case (mode_r)
         lamind_pkg::LAMIND_NORMAL: lamp_nxt = pat_r < lamind_pkg::SLOW_HALF_MS;
         lamind_pkg::LAMIND_LEAK,
         lamind_pkg::LAMIND_TEST: lamp_nxt = pat_r < lamind_pkg::FAST_HALF_MS;
         lamind_pkg::LAMIND_DELAY: lamp_nxt = 1'b1;
         default: lamp_nxt = (pat_r < 32'(blinks) * 2 * lamind_pkg::FLASH_HALF_MS)
                             && ((pat_r / lamind_pkg::FLASH_HALF_MS) % 2 == 0);
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         lamp <= 1'b0;
         hvac_enable <= 1'b0;
         blower_on <= 1'b0;
      end else begin
         lamp <= lamp_nxt;
         // Test mode mitigates too, as it simulates a leak
         hvac_enable <= !(leak_now || delay_r || test_r);
         blower_on <= leak_now || delay_r || test_r;
      end
   end

   assign mode = mode_r;
endmodule
`default_nettype wire

// ===== hdl/lamind_pkg.sv
// Constants for the leak alarm mode indicator
package lamind_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned SLOW_HALF_S = 2;
   localparam int unsigned FAST_HALF_MS = 250;
   localparam int unsigned FAULT_GAP_S = 5;
   localparam int unsigned DELAY_MIN = 5;
   localparam int unsigned TEST_MIN = 5;
   localparam int unsigned DOUBLE_PRESS_S = 5;
   localparam int unsigned FLASH_HALF_MS = 250;
   localparam int unsigned BOARD_BLINKS = 2;
   localparam int unsigned COMM_BLINKS = 3;
   localparam int unsigned SENSOR_BLINKS = 4;
   // Default tick: one millisecond of sys_clk
   localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
   localparam int unsigned SLOW_HALF_MS = SLOW_HALF_S * 1000;
   localparam int unsigned FAULT_GAP_MS = FAULT_GAP_S * 1000;
   localparam int unsigned DELAY_MS = DELAY_MIN * 60_000;
   localparam int unsigned TEST_MS = TEST_MIN * 60_000;
   localparam int unsigned PRESS_MS = DOUBLE_PRESS_S * 1000;
   typedef enum logic [2:0] {
      LAMIND_NORMAL = 3'h0,
      LAMIND_LEAK = 3'h1,
      LAMIND_DELAY = 3'h3,
      LAMIND_TEST = 3'h2,
      LAMIND_BOARD = 3'h6,
      LAMIND_COMM = 3'h7,
      LAMIND_SENSOR = 3'h5
   } lamind_mode_e;
endpackage

// ===== testbench/lamind_assertions.sv
// Port checker for the mode indicator
`timescale 1ns/1ns
`default_nettype none
module lamind_assertions #(
   parameter int unsigned MS_CYCLES = 1
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic leak_seen,
   input wire logic sensor_link_ok,
   input wire logic sensor_error,
   input wire logic relay_fail,
   input wire logic line_short,
   input wire logic button,
   input wire logic lamp,
   input wire logic hvac_enable,
   input wire logic blower_on,
   input wire logic [2:0] mode
);
   localparam int H = lamind_pkg::FAST_HALF_MS * MS_CYCLES;
   logic run_r;
   logic [2:0] m_r;
   logic [15:0] hi_r;
   // Skip the first edge after reset, outputs still forced there
   wire go = !srst && run_r;
   wire bf = relay_fail || line_short;
   always_ff @(posedge sys_clk) begin
      run_r <= !srst;
      m_r <= mode;
      hi_r <= (lamp && mode == 3'h1 && m_r == 3'h1) ? hi_r + 16'h1 : 16'h0;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   property p_leak; go && leak_seen && sensor_link_ok && !bf |=> mode == 3'h1; endproperty
   a_leak: assert property (p_leak) else $error("leak mode");
   property p_board; go && bf && !(leak_seen && sensor_link_ok) |=> mode == 3'h6; endproperty
   a_board: assert property (p_board) else $error("board mode");
   property p_comm; go && !bf && !sensor_link_ok |=> mode == 3'h7; endproperty
   a_comm: assert property (p_comm) else $error("comm mode");
   property p_sens; go && !bf && sensor_link_ok && !leak_seen && sensor_error |=> mode == 3'h5;
   endproperty
   a_sens: assert property (p_sens) else $error("sensor mode");
   property p_mitig; mode == 3'h1 || mode == 3'h3 |-> !hvac_enable && blower_on; endproperty
   a_mitig: assert property (p_mitig) else $error("mitigation outputs");
   property p_solid; mode == 3'h3 && m_r == 3'h3 |-> lamp; endproperty
   a_solid: assert property (p_solid) else $error("delay lamp");
   // A test started during the leak outranks the delay once the leak clears
   property p_clear; go && mode == 3'h1 && !leak_seen && sensor_link_ok && !sensor_error
      && !bf |=> mode == 3'h3 || mode == 3'h2; endproperty
   a_clear: assert property (p_clear) else $error("no delay");
   property p_fast; mode == 3'h1 && m_r == 3'h1 && $fell(lamp) |-> hi_r == H; endproperty
   a_fast: assert property (p_fast) else $error("fast blink");
   c_test: cover property (mode == 3'h2);
   c_comm: cover property (mode == 3'h7);
   c_sens: cover property (mode == 3'h5);
   c_back: cover property (m_r == 3'h3 && mode == 3'h0);
endmodule
bind lamind_top lamind_assertions #(.MS_CYCLES(MS_CYCLES)) chk (
   .sys_clk(sys_clk),
   .srst(srst),
   .leak_seen(leak_seen),
   .sensor_link_ok(sensor_link_ok),
   .sensor_error(sensor_error),
   .relay_fail(relay_fail),
   .line_short(line_short),
   .button(button),
   .lamp(lamp),
   .hvac_enable(hvac_enable),
   .blower_on(blower_on),
   .mode(mode)
);
`default_nettype wire

// ===== testbench/lamind_partner.sv
// Sensor and service button model
`timescale 1ns/1ns
`default_nettype none
module lamind_partner (
   input wire logic sys_clk,
   input wire logic link_req,
   input wire logic leak_req,
   input wire logic err_req,
   input wire logic press_req,
   output logic leak_seen,
   output logic sensor_link_ok,
   output logic sensor_error,
   output logic button
);
   logic tog_r = 1'b0;
   always @(negedge sys_clk) tog_r <= !tog_r;
   // Lost link: lines wander instead of holding the last value
   assign leak_seen = link_req ? leak_req : tog_r;
   assign sensor_error = link_req ? err_req : !tog_r;
   assign sensor_link_ok = link_req;
   assign button = press_req;
endmodule
`default_nettype wire

// ===== testbench/lamind_top_tb.sv
// Self-checking bench for the mode indicator
`timescale 1ns/1ns
`default_nettype none
module lamind_top_tb;
   logic sys_clk = 1'b0, srst = 1'b1, link_req = 1'b1, leak_req = 1'b0, err_req = 1'b0;
   logic press_req = 1'b0, relay_fail = 1'b0, line_short = 1'b0;
   wire logic leak_seen, sensor_link_ok, sensor_error, button, lamp, hvac_enable, blower_on;
   wire logic [2:0] mode;
   int failures = 0, comparisons = 0, cyc = 0, n;
   // Shortened delay and test so both run out inside the run
   localparam int unsigned TB_DELAY_MS = 3000;
   localparam int unsigned TB_TEST_MS = 2000;
   lamind_partner PRT (
      .sys_clk(sys_clk),
      .link_req(link_req),
      .leak_req(leak_req),
      .err_req(err_req),
      .press_req(press_req),
      .leak_seen(leak_seen),
      .sensor_link_ok(sensor_link_ok),
      .sensor_error(sensor_error),
      .button(button)
   );
   lamind_top #(.MS_CYCLES(1), .DELAY_MS(TB_DELAY_MS), .TEST_MS(TB_TEST_MS)) DUT (
      .sys_clk(sys_clk),
      .srst(srst),
      .leak_seen(leak_seen),
      .sensor_link_ok(sensor_link_ok),
      .sensor_error(sensor_error),
      .relay_fail(relay_fail),
      .line_short(line_short),
      .button(button),
      .lamp(lamp),
      .hvac_enable(hvac_enable),
      .blower_on(blower_on),
      .mode(mode)
   );
   initial forever #5 sys_clk = !sys_clk;
   task automatic check(logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      if (failures == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic tick(int k);
      repeat (k) @(negedge sys_clk);
   endtask
   // Length of the next lamp run at level lv
   task automatic span(logic lv);
      while (lamp !== lv) tick(1);
      n = 0;
      while (lamp === lv) begin
         n++;
         tick(1);
      end
   endtask
   task automatic press;
      press_req = 1'b1;
      tick(3);
      press_req = 1'b0;
      tick(3);
   endtask
   // Test mode never active here, so no condition means delay
   function automatic logic [2:0] exp_mode(logic lk, ok, er, rf, ls);
      if (lk && ok) return 3'h1;
      if (rf || ls) return 3'h6;
      if (!ok) return 3'h7;
      if (er) return 3'h5;
      return 3'h3;
   endfunction
   task automatic apply(logic lk, ok, er, rf, ls);
      {leak_req, link_req, err_req, relay_fail, line_short} = {lk, ok, er, rf, ls};
      tick(1);
      check(mode, exp_mode(lk, ok, er, rf, ls));
      tick(1);
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      // Ceiling well above the roughly 47000 cycles the tests take
      if (cyc == 90000) begin
         failures++;
         give_verdict;
      end
   end
   initial begin
      n = $urandom(32'hCE2D6B5C);
      tick(12);
      srst = 1'b0;
      tick(2);
      check(mode, 3'h0);
      span(1'b0);
      span(1'b1);
      check(n, 2000);
      span(1'b0);
      check(n, 2000);
      press;
      press;
      check(mode, 3'h2);
      span(1'b0);
      span(1'b1);
      check(n, 250);
      check({hvac_enable, blower_on}, 2'b01);
      press;
      check(mode, 3'h0);
      press;
      tick(5100);
      press;
      check(mode, 3'h0);
      press;
      check(mode, 3'h2);
      press;
      apply(1, 1, 0, 0, 0);
      span(1'b0);
      span(1'b1);
      check(n, 250);
      check({hvac_enable, blower_on}, 2'b01);
      apply(0, 1, 0, 0, 0);
      tick(3);
      check(lamp, 1);
      apply(1, 1, 0, 0, 0);
      apply(0, 1, 0, 0, 0);
      for (int k = 0; k < 4; k++) begin
         apply(0, k != 2, k == 3, k == 0, k == 1);
         for (int b = 0; b < (k < 2 ? 2 : k + 1); b++) begin
            span(1'b1);
            check(n, 250);
         end
         span(1'b0);
         check(n >= 5000 && n <= 5250, 1);
         span(1'b1);
         check(n, 250);
         apply(0, 1, 0, 0, 0);
      end
      repeat (300) apply(1'($urandom), 1'($urandom), 1'($urandom), $urandom % 8 == 0,
                         $urandom % 8 == 0);
      apply(0, 1, 0, 1, 0);
      apply(0, 1, 0, 0, 0);
      tick(TB_DELAY_MS - 2);
      check(mode, 3'h3);
      tick(1);
      check(mode, 3'h0);
      check({hvac_enable, blower_on}, 2'b10);
      press;
      press;
      check(mode, 3'h2);
      tick(TB_TEST_MS - 5);
      check(mode, 3'h2);
      tick(1);
      check(mode, 3'h0);
      check({hvac_enable, blower_on}, 2'b10);
      give_verdict;
   end
endmodule
`default_nettype wire
